// ### logic/pcpm_pkg.sv
package pcpm_pkg;

  // ----------------------------------------------------------------
  // port geometry
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned BIT_ZERO = 0;
  localparam int unsigned BIT_ONE = 1;
  localparam int unsigned BIT_TWO = 2;
  localparam int unsigned BIT_FOUR = 4;
  localparam int unsigned BIT_FIVE = 5;
  localparam int unsigned BIT_SIX = 6;
  localparam int unsigned BIT_SEVEN = 7;

  // pins that really exist; position three has no pad
  localparam logic [7:0] PIN_MASK = 8'hf7;
  // pins that own a direction bit and a latch bit
  localparam logic [7:0] DIR_MASK = 8'hc7;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_PINS = 4'h0;
  localparam logic [3:0] OFS_LATCH = 4'h4;
  localparam logic [3:0] OFS_DIR = 4'h8;
  localparam logic [3:0] OFS_CFG = 4'hc;

  // ----------------------------------------------------------------
  // configuration register fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_W = 4;
  localparam int unsigned CFG_USB_EN = 0;
  localparam int unsigned CFG_ONCHIP_OFF = 1;
  localparam int unsigned CFG_TOSC_EN = 2;
  localparam int unsigned CFG_CMP_SEL = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hc7;
  localparam logic [3:0] CFG_RST = 4'h8;
  localparam logic [7:0] OE_N_RST = 8'hff;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ### logic/pcpm_pin_if.sv
`timescale 1ns/1ps
interface pcpm_pin_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport sync_side (input raw, output synced);
  modport core_side (output raw, input synced);
endinterface

// ### logic/pcpm_sync.sv
`timescale 1ns/1ps
module pcpm_sync (
  input wire ref_clk,
  input wire arst_n,
  pcpm_pin_if.sync_side pins
);

  // ----------------------------------------------------------------
  // two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] stable;
  } pcpm_sync_t;

  pcpm_sync_t st;
  pcpm_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.meta = pins.raw;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pins.synced = st.stable;

endmodule

// ### logic/pcpm_port.sv
`timescale 1ns/1ps
// Summary of operation
// - direction one tristates, zero drives the latch
// - seven pins; position three absent entirely
// - latch register readable, returns latched value
// - pins four, five: no direction, input only
// - external transceiver: four, five receive minus, plus
// - on-chip transceiver: usb block sets direction
// - external transceiver enable drives pin one
// - reset leaves every directed pin an input
// - pins four, five read only when usb off and on-chip transceiver disabled
// - direction reads stored value despite overrides
// - some peripherals override direction bits; others need them cleared
// - timer oscillator takes pins zero, one
// - pin zero feeds timer clock when input
// - pin one: second compare output or capture
// - pin two: first compare output or capture
// - pin two carries pwm a, may tristate
// - pin six transmit needs direction cleared
// - pin six synchronous clock out or in
// - pin seven serial data, spi data out
// - second compare leaves pin one when select low
module pcpm_port (
  input wire ref_clk,
  input wire arst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  input wire timer_osc_out,
  input wire second_compare_pwm_en,
  input wire second_compare_pwm,
  input wire first_compare_pwm_en,
  input wire first_compare_pwm,
  input wire enhanced_pwm_chan_a_en,
  input wire enhanced_pwm_chan_a,
  input wire enhanced_pwm_shutdown,
  input wire xcvr_output_enable,
  input wire usb_drive,
  input wire usb_dminus_out,
  input wire usb_dplus_out,
  input wire serial_tx_en,
  input wire serial_tx,
  input wire sync_serial_clock_en,
  input wire sync_serial_clock,
  input wire serial_data_out_en,
  input wire serial_data_out,
  input wire spi_data_out_en,
  input wire spi_data_out,
  output logic timer_osc_in,
  output logic timer_ext_clock_in,
  output logic second_compare_capture,
  output logic first_compare_capture,
  output logic xcvr_minus_receive,
  output logic xcvr_plus_receive,
  output logic usb_dminus_in,
  output logic usb_dplus_in,
  output logic sync_serial_clock_in,
  output logic serial_rx_in,
  output logic usb_module_enable,
  output logic onchip_xcvr_disable,
  output logic timer_osc_enable,
  output logic compare_pin_select
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [3:0] cfg;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [9:0] rx;
  } pcpm_state_t;

  pcpm_state_t st;
  pcpm_state_t next_st;

  pcpm_pin_if pin_bus ();

  // pads run free of ref_clk; only the synchronised copy is ever read
  assign pin_bus.raw = pin_in;

  pcpm_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pins(pin_bus.sync_side)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // plain port behaviour: direction zero drives the latch bit
  function automatic logic [1:0] port_drive(input logic dir_bit, input logic latch_bit);
    port_drive = {dir_bit, latch_bit & ~dir_bit};
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [7:0] mask);
    merge_byte = (old & ~mask) | (wd[7:0] & mask);
  endfunction

  // ----------------------------------------------------------------
  // decoded modes
  // ----------------------------------------------------------------
  logic usb_on;
  logic ext_xcvr;
  logic onchip_xcvr;
  logic port_usb_free;
  logic tosc_on;
  logic cmp_here;
  logic [7:0] sy;
  logic [7:0] pin_view;

  assign sy = pin_bus.synced;
  assign usb_on = st.cfg[pcpm_pkg::CFG_USB_EN];
  assign ext_xcvr = usb_on & st.cfg[pcpm_pkg::CFG_ONCHIP_OFF];
  assign onchip_xcvr = usb_on & ~st.cfg[pcpm_pkg::CFG_ONCHIP_OFF];
  assign port_usb_free = ~usb_on & st.cfg[pcpm_pkg::CFG_ONCHIP_OFF];
  assign tosc_on = st.cfg[pcpm_pkg::CFG_TOSC_EN];
  // select low moves the second compare off pin one
  assign cmp_here = st.cfg[pcpm_pkg::CFG_CMP_SEL];

  // digital read view of the pads
  always_comb begin
    pin_view = sy & pcpm_pkg::PIN_MASK;
    if (!port_usb_free) begin
      pin_view[pcpm_pkg::BIT_FOUR] = 1'b0;
      pin_view[pcpm_pkg::BIT_FIVE] = 1'b0;
    end
    if (tosc_on) begin
      pin_view[pcpm_pkg::BIT_ZERO] = 1'b0;
      pin_view[pcpm_pkg::BIT_ONE] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [1:0] d;
  logic take;

  always_comb begin
    next_st = st;
    d = 2'b00;
    take = (avs_read | avs_write) & ~st.ack;

    // ------------------------------------
    // bus slave: one wait cycle, then a single ready cycle
    // ------------------------------------
    // a request still held after its ready cycle is taken again
    next_st.ack = take;
    if (take) begin
      case (avs_address)
        pcpm_pkg::OFS_PINS: next_st.rdata = {24'h00_0000, pin_view};
        pcpm_pkg::OFS_LATCH: next_st.rdata = {24'h00_0000, st.latch};
        pcpm_pkg::OFS_DIR: next_st.rdata = {24'h00_0000, st.dir};
        pcpm_pkg::OFS_CFG: next_st.rdata = {28'h000_0000, st.cfg};
        default: next_st.rdata = pcpm_pkg::WORD_ZERO;
      endcase
    end
    if (st.ack && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        pcpm_pkg::OFS_PINS: begin
          // writing the port writes the latch
          next_st.latch = merge_byte(st.latch, avs_writedata, pcpm_pkg::DIR_MASK);
        end
        pcpm_pkg::OFS_LATCH: begin
          next_st.latch = merge_byte(st.latch, avs_writedata, pcpm_pkg::DIR_MASK);
        end
        pcpm_pkg::OFS_DIR: begin
          next_st.dir = merge_byte(st.dir, avs_writedata, pcpm_pkg::DIR_MASK);
        end
        pcpm_pkg::OFS_CFG: begin
          next_st.cfg = avs_writedata[pcpm_pkg::CFG_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------
    // every pin starts idle: released, low; idle functions do nothing
    // ------------------------------------
    next_st.out = pcpm_pkg::OUT_RST;
    next_st.oe_n = pcpm_pkg::OE_N_RST;

    // ------------------------------------
    // pin zero
    // ------------------------------------
    if (tosc_on) begin
      next_st.out[pcpm_pkg::BIT_ZERO] = timer_osc_out;
      next_st.oe_n[pcpm_pkg::BIT_ZERO] = 1'b0;
    end else begin
      d = port_drive(st.dir[pcpm_pkg::BIT_ZERO], st.latch[pcpm_pkg::BIT_ZERO]);
      {next_st.oe_n[pcpm_pkg::BIT_ZERO], next_st.out[pcpm_pkg::BIT_ZERO]} = d;
    end

    // ------------------------------------
    // pin one
    // ------------------------------------
    if (tosc_on) begin
      // oscillator wins: the pin becomes its input and nothing drives it
      next_st.oe_n[pcpm_pkg::BIT_ONE] = 1'b1;
    end else if (ext_xcvr) begin
      next_st.out[pcpm_pkg::BIT_ONE] = xcvr_output_enable;
      next_st.oe_n[pcpm_pkg::BIT_ONE] = 1'b0;
    end else if (cmp_here && second_compare_pwm_en && !st.dir[pcpm_pkg::BIT_ONE]) begin
      next_st.out[pcpm_pkg::BIT_ONE] = second_compare_pwm;
      next_st.oe_n[pcpm_pkg::BIT_ONE] = 1'b0;
    end else begin
      d = port_drive(st.dir[pcpm_pkg::BIT_ONE], st.latch[pcpm_pkg::BIT_ONE]);
      {next_st.oe_n[pcpm_pkg::BIT_ONE], next_st.out[pcpm_pkg::BIT_ONE]} = d;
    end

    // ------------------------------------
    // pin two: pwm channel a outranks the compare output
    // ------------------------------------
    if (enhanced_pwm_chan_a_en && !st.dir[pcpm_pkg::BIT_TWO]) begin
      next_st.out[pcpm_pkg::BIT_TWO] = enhanced_pwm_chan_a;
      next_st.oe_n[pcpm_pkg::BIT_TWO] = enhanced_pwm_shutdown;
    end else if (first_compare_pwm_en && !st.dir[pcpm_pkg::BIT_TWO]) begin
      next_st.out[pcpm_pkg::BIT_TWO] = first_compare_pwm;
      next_st.oe_n[pcpm_pkg::BIT_TWO] = 1'b0;
    end else begin
      d = port_drive(st.dir[pcpm_pkg::BIT_TWO], st.latch[pcpm_pkg::BIT_TWO]);
      {next_st.oe_n[pcpm_pkg::BIT_TWO], next_st.out[pcpm_pkg::BIT_TWO]} = d;
    end

    // ------------------------------------
    // pins four and five: only the on-chip transceiver ever drives them
    // ------------------------------------
    if (onchip_xcvr) begin
      next_st.out[pcpm_pkg::BIT_FOUR] = usb_dminus_out;
      next_st.out[pcpm_pkg::BIT_FIVE] = usb_dplus_out;
      next_st.oe_n[pcpm_pkg::BIT_FOUR] = ~usb_drive;
      next_st.oe_n[pcpm_pkg::BIT_FIVE] = ~usb_drive;
    end else begin
      // port mode and the external transceiver only ever listen here
      next_st.oe_n[pcpm_pkg::BIT_FOUR] = 1'b1;
      next_st.oe_n[pcpm_pkg::BIT_FIVE] = 1'b1;
      next_st.out[pcpm_pkg::BIT_FOUR] = 1'b0;
      next_st.out[pcpm_pkg::BIT_FIVE] = 1'b0;
    end

    // ------------------------------------
    // pin six: transmit only works with the direction bit cleared
    // ------------------------------------
    if (serial_tx_en && !st.dir[pcpm_pkg::BIT_SIX]) begin
      next_st.out[pcpm_pkg::BIT_SIX] = serial_tx;
      next_st.oe_n[pcpm_pkg::BIT_SIX] = 1'b0;
    end else if (sync_serial_clock_en && !st.dir[pcpm_pkg::BIT_SIX]) begin
      next_st.out[pcpm_pkg::BIT_SIX] = sync_serial_clock;
      next_st.oe_n[pcpm_pkg::BIT_SIX] = 1'b0;
    end else begin
      d = port_drive(st.dir[pcpm_pkg::BIT_SIX], st.latch[pcpm_pkg::BIT_SIX]);
      {next_st.oe_n[pcpm_pkg::BIT_SIX], next_st.out[pcpm_pkg::BIT_SIX]} = d;
    end

    // ------------------------------------
    // pin seven: serial data output forces the pin whatever the direction
    // ------------------------------------
    if (serial_data_out_en) begin
      next_st.out[pcpm_pkg::BIT_SEVEN] = serial_data_out;
      next_st.oe_n[pcpm_pkg::BIT_SEVEN] = 1'b0;
    end else if (spi_data_out_en && !st.dir[pcpm_pkg::BIT_SEVEN]) begin
      next_st.out[pcpm_pkg::BIT_SEVEN] = spi_data_out;
      next_st.oe_n[pcpm_pkg::BIT_SEVEN] = 1'b0;
    end else begin
      d = port_drive(st.dir[pcpm_pkg::BIT_SEVEN], st.latch[pcpm_pkg::BIT_SEVEN]);
      {next_st.oe_n[pcpm_pkg::BIT_SEVEN], next_st.out[pcpm_pkg::BIT_SEVEN]} = d;
    end

    // ------------------------------------
    // receive paths, gated so that idle functions see a quiet zero
    // ------------------------------------
    // a pad edge shows here three clocks later: two sync stages and this one
    next_st.rx[0] = tosc_on & sy[pcpm_pkg::BIT_ONE];
    next_st.rx[1] = ~tosc_on & st.dir[pcpm_pkg::BIT_ZERO] & sy[pcpm_pkg::BIT_ZERO];
    next_st.rx[2] = cmp_here & ~tosc_on & ~ext_xcvr & st.dir[pcpm_pkg::BIT_ONE]
                    & sy[pcpm_pkg::BIT_ONE];
    next_st.rx[3] = st.dir[pcpm_pkg::BIT_TWO] & sy[pcpm_pkg::BIT_TWO];
    next_st.rx[4] = ext_xcvr & sy[pcpm_pkg::BIT_FOUR];
    next_st.rx[5] = ext_xcvr & sy[pcpm_pkg::BIT_FIVE];
    next_st.rx[6] = onchip_xcvr & sy[pcpm_pkg::BIT_FOUR];
    next_st.rx[7] = onchip_xcvr & sy[pcpm_pkg::BIT_FIVE];
    next_st.rx[8] = st.dir[pcpm_pkg::BIT_SIX] & sy[pcpm_pkg::BIT_SIX];
    next_st.rx[9] = st.dir[pcpm_pkg::BIT_SEVEN] & sy[pcpm_pkg::BIT_SEVEN];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // the async branch loads constants only, never other state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st.latch <= pcpm_pkg::LATCH_RST;
      st.dir <= pcpm_pkg::DIR_RST;
      st.cfg <= pcpm_pkg::CFG_RST;
      st.ack <= 1'b0;
      st.rdata <= pcpm_pkg::WORD_ZERO;
      st.out <= pcpm_pkg::OUT_RST;
      st.oe_n <= pcpm_pkg::OE_N_RST;
      st.rx <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = ~st.ack;
  assign pin_out = st.out;
  assign pin_oe_n = st.oe_n;
  assign timer_osc_in = st.rx[0];
  assign timer_ext_clock_in = st.rx[1];
  assign second_compare_capture = st.rx[2];
  assign first_compare_capture = st.rx[3];
  assign xcvr_minus_receive = st.rx[4];
  assign xcvr_plus_receive = st.rx[5];
  assign usb_dminus_in = st.rx[6];
  assign usb_dplus_in = st.rx[7];
  assign sync_serial_clock_in = st.rx[8];
  assign serial_rx_in = st.rx[9];
  assign usb_module_enable = st.cfg[pcpm_pkg::CFG_USB_EN];
  assign onchip_xcvr_disable = st.cfg[pcpm_pkg::CFG_ONCHIP_OFF];
  assign timer_osc_enable = st.cfg[pcpm_pkg::CFG_TOSC_EN];
  assign compare_pin_select = st.cfg[pcpm_pkg::CFG_CMP_SEL];

endmodule

// ### testbench/pcpm_pads.sv
`timescale 1ns/1ps
// ----------------------------------------
// pads and far-side drivers
// ----------------------------------------
module pcpm_pads (
  input wire ref_clk,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe_n,
  input wire [7:0] ext_en,
  input wire [7:0] ext_val,
  output logic [7:0] pin_in
);
  // no pulls on these pads, so a released line wanders every cycle
  logic [7:0] wander = 8'h55;
  always @(posedge ref_clk) begin
    wander <= ~wander;
  end
  // the device wins any overlap with a far-side driver
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & wander);
endmodule

// ### testbench/pcpm_port_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// pin mux checker
// ----------------------------------------
module pcpm_chk (
  input wire ref_clk,
  input wire arst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe_n,
  input wire timer_osc_out,
  input wire enhanced_pwm_chan_a_en,
  input wire enhanced_pwm_chan_a,
  input wire enhanced_pwm_shutdown,
  input wire xcvr_output_enable,
  input wire usb_drive,
  input wire usb_dminus_out,
  input wire usb_dplus_out,
  input wire serial_tx_en,
  input wire serial_tx,
  input wire sync_serial_clock_en,
  input logic usb_module_enable,
  input logic onchip_xcvr_disable,
  input logic timer_osc_enable
);
  // direction is internal, so shadow it from acknowledged writes
  logic [7:0] dir_s;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_s <= pcpm_pkg::DIR_RST;
    end else if (!avs_waitrequest && avs_write && avs_byteenable[0]
        && avs_address == pcpm_pkg::OFS_DIR) begin
      dir_s <= avs_writedata[7:0] & pcpm_pkg::DIR_MASK;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_pad3; pin_oe_n[3] && !pin_out[3]; endproperty
  property p_dir6; !serial_tx_en && !sync_serial_clock_en |=> pin_oe_n[6] == $past(dir_s[6]);
  endproperty
  property p_usb; usb_module_enable && !onchip_xcvr_disable && usb_drive |=> !pin_oe_n[5]
    && !pin_oe_n[4] && pin_out[5] == $past(usb_dplus_out) && pin_out[4] == $past(usb_dminus_out);
  endproperty
  property p_uoe; usb_module_enable && onchip_xcvr_disable && !timer_osc_enable |=>
    !pin_oe_n[1] && pin_out[1] == $past(xcvr_output_enable); endproperty
  property p_osc; timer_osc_enable |=> pin_oe_n[1] && !pin_oe_n[0]
    && pin_out[0] == $past(timer_osc_out); endproperty
  property p_pwma; enhanced_pwm_chan_a_en && !dir_s[2] |=> pin_oe_n[2] ==
    $past(enhanced_pwm_shutdown) && (pin_oe_n[2] || pin_out[2] == $past(enhanced_pwm_chan_a));
  endproperty
  property p_tx; serial_tx_en && !dir_s[6] |=> !pin_oe_n[6] && pin_out[6] == $past(serial_tx);
  endproperty
  property p_dirrd; !avs_waitrequest && avs_read && avs_address == pcpm_pkg::OFS_DIR |->
    avs_readdata == {24'h00_0000, dir_s}; endproperty
  a_pad3: assert property (p_pad3) else $error("pad three active");
  a_dir6: assert property (p_dir6) else $error("pin six direction");
  a_usb: assert property (p_usb) else $error("usb lines not driven");
  a_uoe: assert property (p_uoe) else $error("transceiver enable");
  a_osc: assert property (p_osc) else $error("oscillator pins");
  a_pwma: assert property (p_pwma) else $error("pwm a pin");
  a_tx: assert property (p_tx) else $error("transmit pin");
  a_dirrd: assert property (p_dirrd) else $error("direction readback");
  c_usb: cover property (usb_module_enable && !onchip_xcvr_disable && usb_drive);
  c_shut: cover property (enhanced_pwm_chan_a_en && enhanced_pwm_shutdown);
  c_osc: cover property (timer_osc_enable && !avs_waitrequest);
endmodule

// ### testbench/port_c_pin_mux_gpio_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// pin mux bench
// ----------------------------------------
module port_c_pin_mux_gpio_tb_top;
  logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [7:0] pin_in, pin_out, pin_oe_n, ext_en, ext_val;
  logic timer_osc_out, second_compare_pwm_en, second_compare_pwm, first_compare_pwm_en;
  logic first_compare_pwm, enhanced_pwm_chan_a_en, enhanced_pwm_chan_a, enhanced_pwm_shutdown;
  logic xcvr_output_enable, usb_drive, usb_dminus_out, usb_dplus_out, serial_tx_en, serial_tx;
  logic sync_serial_clock_en, sync_serial_clock, serial_data_out_en, serial_data_out;
  logic spi_data_out_en, spi_data_out, timer_osc_in, timer_ext_clock_in, second_compare_capture;
  logic first_compare_capture, xcvr_minus_receive, xcvr_plus_receive, usb_dminus_in;
  logic usb_dplus_in, sync_serial_clock_in, serial_rx_in, usb_module_enable;
  logic onchip_xcvr_disable, timer_osc_enable, compare_pin_select;
  int error_cnt = 0;
  int samples_checked = 0;
  pcpm_port dut (.*);
  pcpm_pads pads (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= b;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask
  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t reg %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t pins %h exp %h", $time, g, e);
    end
  endtask
  task automatic t_reset();
    rd(pcpm_pkg::OFS_DIR);
    chk_reg({24'h00_0000, pcpm_pkg::DIR_RST}, rdata);
    rd(4'h2);
    chk_reg(pcpm_pkg::WORD_ZERO, rdata);
    chk_pin(pcpm_pkg::OE_N_RST, pin_oe_n);
    $display("t_reset end");
  endtask
  task automatic t_latch();
    bus(1'b1, pcpm_pkg::OFS_LATCH, 32'h0000_00ff, 4'h1);
    bus(1'b1, pcpm_pkg::OFS_LATCH, 32'h0000_0000, 4'he);
    wr(pcpm_pkg::OFS_DIR, 32'h0000_0000);
    tick(3);
    chk_pin(~pcpm_pkg::DIR_MASK, pin_oe_n);
    chk_pin(pcpm_pkg::DIR_MASK, pin_out & pcpm_pkg::DIR_MASK);
    wr(pcpm_pkg::OFS_DIR, 32'h0000_00ff);
    ext_en <= pcpm_pkg::DIR_MASK;
    ext_val <= 8'h00;
    tick(5);
    rd(pcpm_pkg::OFS_PINS);
    chk_reg(pcpm_pkg::WORD_ZERO, rdata & 32'h0000_00c7);
    rd(pcpm_pkg::OFS_LATCH);
    chk_reg({24'h00_0000, pcpm_pkg::DIR_MASK}, rdata);
    $display("t_latch end");
  endtask
  task automatic t_usb();
    ext_en <= 8'h30;
    ext_val <= 8'h10;
    tick(5);
    rd(pcpm_pkg::OFS_PINS);
    chk_reg(pcpm_pkg::WORD_ZERO, rdata & 32'h0000_0030);
    wr(pcpm_pkg::OFS_CFG, 32'h0000_000a);
    tick(5);
    rd(pcpm_pkg::OFS_PINS);
    chk_reg(32'h0000_0010, rdata & 32'h0000_0030);
    xcvr_output_enable <= 1'b1;
    wr(pcpm_pkg::OFS_CFG, 32'h0000_000b);
    tick(5);
    chk_pin(8'h01, {6'h00, xcvr_plus_receive, xcvr_minus_receive});
    chk_pin(8'h0b, {4'h0, compare_pin_select, timer_osc_enable, onchip_xcvr_disable,
      usb_module_enable});
    chk_pin(8'h0d, {4'h0, pin_oe_n[5:4], pin_oe_n[1], pin_out[1]});
    ext_en <= 8'h00;
    usb_drive <= 1'b1;
    usb_dminus_out <= 1'b1;
    wr(pcpm_pkg::OFS_CFG, 32'h0000_0009);
    tick(3);
    chk_pin(8'h01, {4'h0, pin_oe_n[5:4], pin_out[5:4]});
    usb_drive <= 1'b0;
    ext_en <= 8'h30;
    ext_val <= 8'h20;
    tick(5);
    chk_pin(8'h0e, {4'h0, pin_oe_n[5:4], usb_dplus_in, usb_dminus_in});
    ext_en <= 8'h83;
    ext_val <= 8'h83;
    wr(pcpm_pkg::OFS_CFG, 32'h0000_0008);
    $display("t_usb end");
  endtask
  task automatic t_timer();
    tick(5);
    chk_pin(8'h07, {5'h00, serial_rx_in, second_compare_capture, timer_ext_clock_in});
    ext_en <= 8'h02;
    timer_osc_out <= 1'b1;
    wr(pcpm_pkg::OFS_CFG, 32'h0000_000c);
    tick(5);
    chk_pin(8'h05, {5'h00, pin_oe_n[1:0], pin_out[0]});
    chk_pin(8'h01, {5'h00, second_compare_capture, timer_ext_clock_in, timer_osc_in});
    wr(pcpm_pkg::OFS_CFG, 32'h0000_0008);
    $display("t_timer end");
  endtask
  task automatic t_periph();
    wr(pcpm_pkg::OFS_PINS, 32'h0000_0000);
    wr(pcpm_pkg::OFS_DIR, 32'h0000_0000);
    {second_compare_pwm_en, second_compare_pwm, first_compare_pwm_en, first_compare_pwm} <= 4'hf;
    {serial_tx_en, serial_tx, spi_data_out_en, spi_data_out, sync_serial_clock_en} <= 5'h1f;
    tick(3);
    chk_pin(8'hc6, pin_out & pcpm_pkg::DIR_MASK);
    chk_pin(8'h38, pin_oe_n);
    serial_tx_en <= 1'b0;
    enhanced_pwm_chan_a_en <= 1'b1;
    wr(pcpm_pkg::OFS_CFG, 32'h0000_0000);
    tick(3);
    chk_pin(8'h80, pin_out & pcpm_pkg::DIR_MASK);
    enhanced_pwm_shutdown <= 1'b1;
    {serial_data_out_en, serial_data_out, sync_serial_clock} <= 3'h4;
    tick(3);
    chk_pin(8'h04, pin_oe_n & 8'h04);
    ext_en <= 8'h44;
    ext_val <= 8'h44;
    wr(pcpm_pkg::OFS_DIR, 32'h0000_00ff);
    tick(5);
    chk_pin(8'h7f, pin_oe_n);
    chk_pin(8'h03, {6'h00, first_compare_capture, sync_serial_clock_in});
    rd(pcpm_pkg::OFS_DIR);
    chk_reg({24'h00_0000, pcpm_pkg::DIR_MASK}, rdata);
    $display("t_periph end");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata, ext_en, ext_val} = '0;
    {timer_osc_out, second_compare_pwm_en, second_compare_pwm, first_compare_pwm_en,
      first_compare_pwm, enhanced_pwm_chan_a_en, enhanced_pwm_chan_a, enhanced_pwm_shutdown,
      xcvr_output_enable, usb_drive, usb_dminus_out, usb_dplus_out, serial_tx_en, serial_tx,
      sync_serial_clock_en, sync_serial_clock, serial_data_out_en, serial_data_out,
      spi_data_out_en, spi_data_out} = '0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_latch();
    t_usb();
    t_timer();
    t_periph();
    tally_and_finish();
  end
endmodule
bind pcpm_port pcpm_chk chk (.*);
